//--- logic/dmac_datapath.sv
/*
  Dual multiplier datapath: multiply-accumulate on the upper lane and plain
  multiply on the lower lane in one cycle, with mode register, overflow
  flags, pointers and accumulators reachable over classic Wishbone.
  Assumes memory read buses answer combinationally to the addresses driven
  in the same cycle as instr_valid_i.
*/
// Decided for this implementation: the Wishbone slave port and the placing of the registers.
`timescale 1ns/1ns
module dmac_datapath
  import dmac_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic instr_valid_i,
  input wire dmac_instr_s instr_i,
  input wire dmac_rd_s rd_i,
  output logic [15:0] data_address_o,
  output logic [15:0] data_pair_address_o,
  output logic [15:0] coeff_address_bus_high_o,
  output logic [15:0] coeff_address_bus_low_o,
  output logic [3:0] ovf_flags_o
);

  typedef struct packed {
    dmac_ctrl_s ctrl;
    logic [3:0] ovf;
    logic bad;
    logic [15:0] dptr;
    logic [15:0] cptr;
    logic [3:0][39:0] acc;
    logic ack;
    logic [31:0] dat;
  } dmac_state_s;

  dmac_state_s st;
  dmac_state_s next_st;
  logic exec;
  logic long_op;
  logic shifted_op;
  logic wide_eff;
  logic [15:0] hi_data;
  logic [31:0] prod_hi;
  logic [31:0] prod_lo;
  logic [39:0] src_y;
  dmac_res_s res_y;
  dmac_res_s res_x;
  logic [15:0] dstep;

  // ==========================================================================
  // helpers
  // byte-lane merge for Wishbone select
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (sel[i])
      begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  // add, round, detect overflow, saturate; 42 bits keep the carry visible
  function automatic dmac_res_s accum(input logic [39:0] src, input logic [31:0] p,
                                      input logic rnd, input logic unb,
                                      input logic wide, input logic sat);
    logic [41:0] sum;
    logic [41:0] rs;
    dmac_res_s r;
    sum = {{2{src[39]}}, src} + {{10{p[31]}}, p};
    rs = sum;
    if (rnd)
    begin
      rs = sum + RND_ADD;
      rs[15:0] = 16'h0000;
      if (unb && (sum[15:0] == RND_HALF))
      begin
        rs[16] = 1'b0; // unbiased: exact halves go to even
      end
    end
    r.ovf = wide ? (rs[41:39] != {3{rs[41]}}) : (rs[41:31] != {11{rs[41]}});
    r.val = rs[39:0];
    if (r.ovf && sat)
    begin
      if (wide)
      begin
        r.val = rs[41] ? SAT40_NEG : SAT40_POS;
      end
      else
      begin
        r.val = rs[41] ? SAT32_NEG : SAT32_POS;
      end
    end
    return r;
  endfunction : accum

  // ==========================================================================
  // decode and address generation
  assign exec = instr_valid_i && (instr_i.prefix == OP_PREFIX) && (instr_i.sub == OP_SUB)
                && (instr_i.variant <= VAR_LONG_SH);
  assign long_op = (instr_i.variant == VAR_LONG) || (instr_i.variant == VAR_LONG_SH);
  assign shifted_op = (instr_i.variant == VAR_SHARED_SH) || (instr_i.variant == VAR_LONG_SH);
  assign wide_eff = st.ctrl.wide | instr_i.wide_q;
  assign dstep = long_op ? DATA_STEP_LONG : DATA_STEP_WORD;

  // addresses come straight from pointer flops; pairs flip bit 0
  assign data_address_o = st.dptr;
  assign data_pair_address_o = st.dptr ^ PAIR_FLIP;
  assign coeff_address_bus_high_o = st.cptr;
  assign coeff_address_bus_low_o = st.cptr ^ PAIR_FLIP;

  // ==========================================================================
  // multiplier lanes
  // shared forms reuse the single bus-d word on both lanes
  assign hi_data = long_op ? rd_i.c : rd_i.d;

  dmac_mul_unit u_upper_multiplier (
    .op_a_i(hi_data),
    .op_b_i(rd_i.bh),
    .uns_a_i(instr_i.uns_d),
    .uns_b_i(instr_i.uns_c),
    .frac_i(st.ctrl.frac),
    .mul_sat_i(st.ctrl.mul_sat),
    .prod_o(prod_hi)
  );

  dmac_mul_unit u_lower_multiplier (
    .op_a_i(rd_i.d),
    .op_b_i(rd_i.bl),
    .uns_a_i(instr_i.uns_d),
    .uns_b_i(instr_i.uns_c),
    .frac_i(st.ctrl.frac),
    .mul_sat_i(st.ctrl.mul_sat),
    .prod_o(prod_lo)
  );

  // ==========================================================================
  // accumulate and plain multiply
  // arithmetic shift keeps the sign of bit 39 in the vacated bits
  assign src_y = shifted_op ? {{ACC_SHIFT{st.acc[instr_i.my][39]}},
                               st.acc[instr_i.my][39:ACC_SHIFT]}
                            : st.acc[instr_i.my];
  assign res_y = accum(src_y, prod_hi, instr_i.rnd_q, st.ctrl.unbiased, wide_eff,
                       st.ctrl.acc_sat);
  assign res_x = accum(ACC_RST, prod_lo, instr_i.rnd_q, st.ctrl.unbiased, wide_eff,
                       st.ctrl.acc_sat);

  // ==========================================================================
  // next state: bus access first, instruction effects override it
  always_comb
  begin
    logic [31:0] merged;
    merged = 32'h0000_0000;
    next_st = st;
    next_st.ack = wb_cyc_i && wb_stb_i && !st.ack;
    next_st.dat = 32'h0000_0000;
    if (next_st.ack && !wb_we_i)
    begin
      if (wb_adr_i == REG_CTRL)
      begin
        next_st.dat = {27'h000_0000, st.ctrl};
      end
      else if (wb_adr_i == REG_STATUS)
      begin
        next_st.dat = {27'h000_0000, st.bad, st.ovf};
      end
      else if (wb_adr_i == REG_PTR)
      begin
        next_st.dat = {st.cptr, st.dptr};
      end
      else if (wb_adr_i[7:4] == ACC_LO_PAGE)
      begin
        next_st.dat = st.acc[wb_adr_i[3:2]][31:0];
      end
      else if (wb_adr_i[7:4] == ACC_HI_PAGE)
      begin
        next_st.dat = {24'h00_0000, st.acc[wb_adr_i[3:2]][39:32]};
      end
    end
    if (next_st.ack && wb_we_i)
    begin
      if (wb_adr_i == REG_CTRL)
      begin
        merged = merge({27'h000_0000, st.ctrl}, wb_dat_i, wb_sel_i);
        next_st.ctrl = merged[CTRL_W-1:0];
      end
      else if (wb_adr_i == REG_STATUS)
      begin
        // write one to clear; a same-cycle set below still wins
        merged = merge(32'h0000_0000, wb_dat_i, wb_sel_i);
        next_st.ovf = st.ovf & ~merged[3:0];
        next_st.bad = st.bad & ~merged[STAT_BAD_BIT];
      end
      else if (wb_adr_i == REG_PTR)
      begin
        {next_st.cptr, next_st.dptr} = merge({st.cptr, st.dptr}, wb_dat_i, wb_sel_i);
      end
      else if (wb_adr_i[7:4] == ACC_LO_PAGE)
      begin
        next_st.acc[wb_adr_i[3:2]][31:0] = merge(st.acc[wb_adr_i[3:2]][31:0], wb_dat_i,
                                                 wb_sel_i);
      end
      else if (wb_adr_i[7:4] == ACC_HI_PAGE)
      begin
        merged = merge({24'h00_0000, st.acc[wb_adr_i[3:2]][39:32]}, wb_dat_i, wb_sel_i);
        next_st.acc[wb_adr_i[3:2]][39:32] = merged[7:0];
      end
    end
    // unrecognised words are dropped and flagged, never executed
    if (instr_valid_i && !exec)
    begin
      next_st.bad = 1'b1;
    end
    if (exec)
    begin
      // product destination first so a shared destination keeps the mac result
      next_st.acc[instr_i.px] = res_x.val;
      next_st.acc[instr_i.my] = res_y.val;
      if (res_x.ovf)
      begin
        next_st.ovf[instr_i.px] = 1'b1;
      end
      if (res_y.ovf)
      begin
        next_st.ovf[instr_i.my] = 1'b1;
      end
      if (instr_i.dmod == MOD_INC)
      begin
        next_st.dptr = st.dptr + dstep;
      end
      else if (instr_i.dmod == MOD_DEC)
      begin
        next_st.dptr = st.dptr - dstep;
      end
      if (instr_i.cmod == MOD_INC)
      begin
        next_st.cptr = st.cptr + COEFF_STEP;
      end
      else if (instr_i.cmod == MOD_DEC)
      begin
        next_st.cptr = st.cptr - COEFF_STEP;
      end
    end
  end

  // ==========================================================================
  // state register
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st <= '0;
      st.ctrl <= CTRL_RST;
      st.dptr <= PTR_RST;
      st.cptr <= PTR_RST;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign wb_ack_o = st.ack;
  assign wb_dat_o = st.dat;
  assign ovf_flags_o = st.ovf;

  // ==========================================================================
  // checks
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  property p_shift_mac;
    (exec && (instr_i.variant == VAR_SHARED_SH) && !instr_i.rnd_q && !res_y.ovf
     && (instr_i.px != instr_i.my))
    |=> st.acc[$past(instr_i.my)] == $past({{16{st.acc[instr_i.my][39]}},
        st.acc[instr_i.my][39:16]} + {{8{prod_hi[31]}}, prod_hi});
  endproperty
  a_shift_mac: assert property (p_shift_mac) else $error("shifted mac result wrong");

  property p_shared_data;
    exec && !long_op |-> (hi_data == rd_i.d);
  endproperty
  a_shared_data: assert property (p_shared_data) else $error("lanes not sharing data");

  property p_coeff_pair;
    coeff_address_bus_low_o == {coeff_address_bus_high_o[15:1], ~coeff_address_bus_high_o[0]};
  endproperty
  a_coeff_pair: assert property (p_coeff_pair) else $error("coeff pair address wrong");

  property p_frac_lsb;
    exec && st.ctrl.frac |-> ((prod_lo[0] == 1'b0) || (prod_lo == PROD_SAT))
                             && ((prod_hi[0] == 1'b0) || (prod_hi == PROD_SAT));
  endproperty
  a_frac_lsb: assert property (p_frac_lsb) else $error("fractional product lsb set");

  property p_mul_sat;
    exec && st.ctrl.frac && st.ctrl.mul_sat && !instr_i.uns_d && !instr_i.uns_c
    && (hi_data == 16'h8000) && (rd_i.bh == 16'h8000) |-> prod_hi == 32'h7fff_ffff;
  endproperty
  a_mul_sat: assert property (p_mul_sat) else $error("product not saturated");

  property p_plain_mul;
    exec && !instr_i.rnd_q && !res_x.ovf && (instr_i.px != instr_i.my)
    |=> st.acc[$past(instr_i.px)] == {{8{$past(prod_lo[31])}}, $past(prod_lo)};
  endproperty
  a_plain_mul: assert property (p_plain_mul) else $error("plain product wrong");

  property p_round_low;
    exec && instr_i.rnd_q && !st.ctrl.acc_sat |=> st.acc[$past(instr_i.px)][15:0] == 16'h0000;
  endproperty
  a_round_low: assert property (p_round_low) else $error("rounded low half nonzero");

  property p_ovf_flag;
    exec && res_y.ovf |=> st.ovf[$past(instr_i.my)] ##1 1'b1;
  endproperty
  a_ovf_flag: assert property (p_ovf_flag) else $error("overflow flag not set");

  property p_sat32;
    exec && res_x.ovf && st.ctrl.acc_sat && !wide_eff && (instr_i.px != instr_i.my)
    |=> (st.acc[$past(instr_i.px)] == SAT32_POS) || (st.acc[$past(instr_i.px)] == SAT32_NEG);
  endproperty
  a_sat32: assert property (p_sat32) else $error("32-bit saturation missing");

  property p_wide_local;
    exec && instr_i.wide_q && !(wb_cyc_i && wb_stb_i && wb_we_i) |=> $stable(st.ctrl.wide);
  endproperty
  a_wide_local: assert property (p_wide_local) else $error("stored wide mode changed");

  property p_cptr_step;
    exec && (instr_i.cmod == MOD_INC) && !(wb_cyc_i && wb_stb_i && wb_we_i)
    |=> st.cptr == $past(st.cptr) + 16'h0002;
  endproperty
  a_cptr_step: assert property (p_cptr_step) else $error("coeff pointer step wrong");

  property p_bad_ignored;
    instr_valid_i && !exec && !(wb_cyc_i && wb_stb_i) |=> $stable(st.acc) && st.bad;
  endproperty
  a_bad_ignored: assert property (p_bad_ignored) else $error("bad word executed");

endmodule : dmac_datapath

//--- logic/dmac_pkg.sv
/*
  Shared constants and carrier types of the dual multiply datapath: register
  map, instruction fields, pointer steps and saturation values.
  Assumes a single synchronous clock domain and a classic Wishbone master.
*/
package dmac_pkg;

  // ==========================================================================
  // register map (byte addresses, one 32-bit word each)
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_PTR = 8'h08;
  localparam logic [3:0] ACC_LO_PAGE = 4'h1;
  localparam logic [3:0] ACC_HI_PAGE = 4'h2;
  localparam int CTRL_W = 5;
  localparam int STAT_BAD_BIT = 4;

  // ==========================================================================
  // reset values
  localparam logic [CTRL_W-1:0] CTRL_RST = 5'h00;
  localparam logic [15:0] PTR_RST = 16'h0000;
  localparam logic [39:0] ACC_RST = 40'h00_0000_0000;

  // ==========================================================================
  // instruction encoding
  localparam logic [7:0] OP_PREFIX = 8'hfd;
  localparam logic [2:0] OP_SUB = 3'b010;
  localparam logic [2:0] VAR_SHARED = 3'h0;
  localparam logic [2:0] VAR_SHARED_SH = 3'h1;
  localparam logic [2:0] VAR_LONG = 3'h2;
  localparam logic [2:0] VAR_LONG_SH = 3'h3;
  localparam logic [1:0] MOD_INC = 2'h1;
  localparam logic [1:0] MOD_DEC = 2'h2;

  // ==========================================================================
  // address generator steps and arithmetic constants
  localparam logic [15:0] DATA_STEP_WORD = 16'h0001;
  localparam logic [15:0] DATA_STEP_LONG = 16'h0002;
  localparam logic [15:0] COEFF_STEP = 16'h0002;
  localparam logic [15:0] PAIR_FLIP = 16'h0001;
  localparam int ACC_SHIFT = 16;
  localparam logic [15:0] MIN_FRAC_OP = 16'h8000;
  localparam logic [31:0] PROD_SAT = 32'h7fff_ffff;
  localparam logic [41:0] RND_ADD = 42'h000_0000_8000;
  localparam logic [15:0] RND_HALF = 16'h8000;
  localparam logic [39:0] SAT32_POS = 40'h00_7fff_ffff;
  localparam logic [39:0] SAT32_NEG = 40'hff_8000_0000;
  localparam logic [39:0] SAT40_POS = 40'h7f_ffff_ffff;
  localparam logic [39:0] SAT40_NEG = 40'h80_0000_0000;

  // ==========================================================================
  // carrier types
  typedef struct packed {
    logic frac;
    logic mul_sat;
    logic unbiased;
    logic wide;
    logic acc_sat;
  } dmac_ctrl_s;

  typedef struct packed {
    logic [7:0] prefix;
    logic [4:0] spare;
    logic [1:0] dmod;
    logic indirect;
    logic [2:0] variant;
    logic [2:0] sub;
    logic [1:0] cmod;
    logic [1:0] px;
    logic [1:0] my;
    logic uns_d;
    logic uns_c;
    logic wide_q;
    logic rnd_q;
  } dmac_instr_s;

  typedef struct packed {
    logic [15:0] d;
    logic [15:0] c;
    logic [15:0] bl;
    logic [15:0] bh;
  } dmac_rd_s;

  typedef struct packed {
    logic ovf;
    logic [39:0] val;
  } dmac_res_s;

endpackage : dmac_pkg

//--- logic/dmac_mul_unit.sv
/*
  One 17x17 multiplier lane: operand extension, fractional shift and
  product saturation. Purely combinational; the caller registers results.
*/
`timescale 1ns/1ns
module dmac_mul_unit
  import dmac_pkg::*;
(
  input wire logic [15:0] op_a_i,
  input wire logic [15:0] op_b_i,
  input wire logic uns_a_i,
  input wire logic uns_b_i,
  input wire logic frac_i,
  input wire logic mul_sat_i,
  output logic [31:0] prod_o
);

  logic signed [16:0] ext_a;
  logic signed [16:0] ext_b;
  logic signed [33:0] raw;
  logic [33:0] shifted;
  logic both_min;

  // ==========================================================================
  // extension, product, fractional shift
  assign ext_a = uns_a_i ? {1'b0, op_a_i} : {op_a_i[15], op_a_i};
  assign ext_b = uns_b_i ? {1'b0, op_b_i} : {op_b_i[15], op_b_i};
  assign raw = ext_a * ext_b;
  assign shifted = frac_i ? {raw[32:0], 1'b0} : raw;

  // only the signed minimum squared can overflow a fractional product of two signed operands
  assign both_min = (op_a_i == MIN_FRAC_OP) && (op_b_i == MIN_FRAC_OP) && !uns_a_i && !uns_b_i;
  assign prod_o = (frac_i && mul_sat_i && both_min) ? PROD_SAT : shifted[31:0];

endmodule : dmac_mul_unit

//--- bench/dmac_mem_model.sv
/*
  Memory side of the dual multiply datapath: data and coefficient words
  answered combinationally on the four read buses.
  Assumes the bench preloads words by hierarchical assignment.
*/
`timescale 1ns/1ns
module dmac_mem_model
  import dmac_pkg::*;
(
  input wire logic [15:0] data_address_i,
  input wire logic [15:0] data_pair_address_i,
  input wire logic [15:0] coeff_high_i,
  input wire logic [15:0] coeff_low_i,
  input wire dmac_instr_s instr_i,
  output dmac_rd_s rd_o
);
  // ==========================================================================
  // storage
  logic [15:0] dmem [256];
  logic [15:0] cmem [256]; // coefficients live in internal memory only

  // fill with a pattern so untouched words never read as unknown
  initial
  begin
    for (int i = 0; i < 256; i++)
    begin
      dmem[i] = 16'h5a00 + 16'(i);
      cmem[i] = 16'ha500 + 16'(i);
    end
  end

  // ==========================================================================
  // read buses; long forms take bus d from the pair address
  assign rd_o = {
    instr_i.variant[1] ? dmem[data_pair_address_i[7:0]] : dmem[data_address_i[7:0]],
    dmem[data_address_i[7:0]],
    cmem[coeff_low_i[7:0]],
    cmem[coeff_high_i[7:0]]};
endmodule : dmac_mem_model

//--- bench/testbench.sv
/*
  Self-checking bench of the dual multiply datapath: register access over
  classic Wishbone and every instruction variant with its modes, except coefficient pointer decrement.
  Assumes dmac_mem_model answers the read buses combinationally.
*/
`timescale 1ns/1ns
module testbench
  import dmac_pkg::*;
;
  // ==========================================================================
  // signals
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, instr_valid_i;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i, ovf_flags_o;
  logic [31:0] wb_dat_i, wb_dat_o, junk;
  logic [15:0] data_address_o, data_pair_address_o, coeff_address_bus_high_o;
  logic [15:0] coeff_address_bus_low_o;
  dmac_instr_s instr_i;
  dmac_rd_s rd_i;
  int n_fail, comparisons, cycles;

  dmac_datapath u_dmac_datapath (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .instr_valid_i(instr_valid_i), .instr_i(instr_i), .rd_i(rd_i),
    .data_address_o(data_address_o), .data_pair_address_o(data_pair_address_o),
    .coeff_address_bus_high_o(coeff_address_bus_high_o),
    .coeff_address_bus_low_o(coeff_address_bus_low_o), .ovf_flags_o(ovf_flags_o));

  dmac_mem_model u_dmac_mem_model (.data_address_i(data_address_o),
    .data_pair_address_i(data_pair_address_o), .coeff_high_i(coeff_address_bus_high_o),
    .coeff_low_i(coeff_address_bus_low_o), .instr_i(instr_i), .rd_o(rd_i));

  // ==========================================================================
  // clock and hang guard; ceiling well above the few hundred cycles needed
  initial
  begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  always @(posedge clk_i)
  begin
    cycles <= cycles + 1;
    if (cycles == 4000)
    begin
      n_fail++;
      end_sim();
    end
  end

  // ==========================================================================
  // shared helpers
  task automatic end_sim;
    if (n_fail == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : end_sim

  task automatic check(input logic [39:0] seen, input logic [39:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // one classic cycle; request held until ack is sampled high
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] wd,
                    output logic [31:0] rd);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= wd;
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1)
      @(posedge clk_i);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    @(posedge clk_i);
  endtask : wb

  task automatic set_acc(input logic [1:0] i, input logic [39:0] v);
    wb(1'b1, {ACC_LO_PAGE, i, 2'b00}, v[31:0], junk);
    wb(1'b1, {ACC_HI_PAGE, i, 2'b00}, {24'h000000, v[39:32]}, junk);
  endtask : set_acc

  task automatic chk_acc(input logic [1:0] i, input logic [39:0] exp);
    logic [31:0] lo, hi;
    wb(1'b0, {ACC_LO_PAGE, i, 2'b00}, 32'h0, lo);
    wb(1'b0, {ACC_HI_PAGE, i, 2'b00}, 32'h0, hi);
    check({hi[7:0], lo}, exp);
  endtask : chk_acc

  task automatic chk_reg(input logic [7:0] adr, input logic [31:0] exp);
    logic [31:0] v;
    wb(1'b0, adr, 32'h0, v);
    check(40'(v), 40'(exp));
  endtask : chk_reg

  // q holds unsigned data, unsigned coeff, 40 qualifier, round qualifier
  function automatic dmac_instr_s mk(input logic [2:0] v, input logic [1:0] dm,
    input logic [1:0] cm, input logic [1:0] px, input logic [1:0] my, input logic [3:0] q);
    mk = {OP_PREFIX, 5'h00, dm, 1'b0, v, OP_SUB, cm, px, my, q};
  endfunction : mk

  task automatic run(input dmac_instr_s ins);
    instr_i <= ins;
    instr_valid_i <= 1'b1;
    @(posedge clk_i);
    instr_valid_i <= 1'b0;
    @(posedge clk_i);
  endtask : run

  // ==========================================================================
  // scenarios
  task automatic t_regs;
    chk_reg(REG_CTRL, 32'h0);
    chk_reg(REG_PTR, 32'h0);
    chk_acc(2'd0, 40'h0);
    wb(1'b1, REG_CTRL, 32'hffff_ffff, junk);
    chk_reg(REG_CTRL, 32'h0000_001f);
    wb(1'b1, 8'h30, 32'hffff_ffff, junk);
    chk_reg(8'h30, 32'h0);
    wb(1'b1, REG_CTRL, 32'h0, junk);
  endtask : t_regs

  task automatic t_shared;
    u_dmac_mem_model.dmem[8'h11] = 16'hfe00;
    u_dmac_mem_model.cmem[8'h20] = 16'h8000;
    u_dmac_mem_model.cmem[8'h21] = 16'h4000;
    wb(1'b1, REG_PTR, 32'h0020_0011, junk);
    set_acc(2'd1, 40'h00_0000_8000);
    set_acc(2'd0, 40'hff_8000_0000);
    check(40'(coeff_address_bus_low_o), 40'h21);
    run(mk(VAR_SHARED, MOD_DEC, MOD_INC, 2'd0, 2'd1, 4'hc));
    chk_acc(2'd1, 40'h00_7f00_8000);
    chk_acc(2'd0, 40'h00_3f80_0000);
    chk_reg(REG_PTR, 32'h0022_0010);
    check(40'(data_address_o), 40'h10);
    check(40'(coeff_address_bus_high_o), 40'h22);
    check(40'(data_pair_address_o), 40'h11);
    check(40'(coeff_address_bus_low_o), 40'h23);
  endtask : t_shared

  task automatic t_shifted;
    u_dmac_mem_model.dmem[8'h10] = 16'h0002;
    u_dmac_mem_model.cmem[8'h22] = 16'h0003;
    u_dmac_mem_model.cmem[8'h23] = 16'hffff;
    set_acc(2'd2, 40'h80_0000_0000);
    run(mk(VAR_SHARED_SH, 2'd0, 2'd0, 2'd3, 2'd2, 4'h0));
    chk_acc(2'd2, 40'hff_ff80_0006);
    chk_acc(2'd3, 40'hff_ffff_fffe);
    check(40'(ovf_flags_o), 40'h0);
  endtask : t_shifted

  task automatic t_long;
    u_dmac_mem_model.dmem[8'h30] = 16'h0004;
    u_dmac_mem_model.dmem[8'h31] = 16'h0005;
    u_dmac_mem_model.cmem[8'h24] = 16'h0010;
    u_dmac_mem_model.cmem[8'h25] = 16'h0100;
    wb(1'b1, REG_PTR, 32'h0024_0030, junk);
    set_acc(2'd1, 40'h00_0001_0000);
    run(mk(VAR_LONG_SH, 2'd0, 2'd0, 2'd0, 2'd1, 4'h0));
    chk_acc(2'd1, 40'h00_0000_0041);
    run(mk(VAR_LONG, MOD_INC, 2'd0, 2'd0, 2'd1, 4'h0));
    chk_acc(2'd1, 40'h00_0000_0081);
    chk_acc(2'd0, 40'h00_0000_0500);
    chk_reg(REG_PTR, 32'h0024_0032);
  endtask : t_long

  task automatic t_frac;
    u_dmac_mem_model.dmem[8'h40] = 16'h8000;
    u_dmac_mem_model.cmem[8'h26] = 16'h8000;
    u_dmac_mem_model.cmem[8'h27] = 16'h4000;
    wb(1'b1, REG_PTR, 32'h0026_0040, junk);
    for (int s = 1; s >= 0; s--)
    begin
      wb(1'b1, REG_CTRL, {27'h0, 1'b1, s[0], 3'h0}, junk);
      set_acc(2'd1, 40'h0);
      run(mk(VAR_SHARED, 2'd0, 2'd0, 2'd0, 2'd1, 4'h0));
      chk_acc(2'd1, s ? 40'h00_7fff_ffff : 40'hff_8000_0000);
      chk_acc(2'd0, 40'hff_c000_0000);
    end
  endtask : t_frac

  task automatic t_round;
    u_dmac_mem_model.dmem[8'h50] = 16'h0001;
    u_dmac_mem_model.cmem[8'h28] = 16'h8003;
    u_dmac_mem_model.cmem[8'h29] = 16'h8000;
    wb(1'b1, REG_PTR, 32'h0028_0050, junk);
    for (int r = 0; r < 2; r++)
    begin
      wb(1'b1, REG_CTRL, {29'h0, r[0], 2'b00}, junk);
      set_acc(2'd1, 40'h00_0001_0000);
      run(mk(VAR_SHARED, 2'd0, 2'd0, 2'd0, 2'd1, 4'h5));
      chk_acc(2'd1, 40'h00_0002_0000);
      chk_acc(2'd0, r ? 40'h0 : 40'h00_0001_0000);
    end
  endtask : t_round

  // table rows: stored wide mode, 40 qualifier, saturate enable; mac result
  task automatic t_ovf;
    logic [2:0] wq [4] = '{3'b011, 3'b001, 3'b000, 3'b100};
    logic [39:0] ea [4] = '{40'h00_8000_0000, 40'h00_7fff_ffff, 40'h00_8000_0000,
                            40'h00_8000_0000};
    u_dmac_mem_model.dmem[8'h60] = 16'h0001;
    u_dmac_mem_model.cmem[8'h2a] = 16'h0001;
    u_dmac_mem_model.cmem[8'h2b] = 16'h0001;
    wb(1'b1, REG_PTR, 32'h002a_0060, junk);
    for (int k = 0; k < 4; k++)
    begin
      wb(1'b1, REG_CTRL, {30'h0, wq[k][2], wq[k][0]}, junk);
      wb(1'b1, REG_STATUS, 32'h0000_001f, junk);
      set_acc(2'd1, 40'h00_7fff_ffff);
      run(mk(VAR_SHARED, 2'd0, 2'd0, 2'd0, 2'd1, {2'b00, wq[k][1], 1'b0}));
      chk_acc(2'd1, ea[k]);
      check(40'(ovf_flags_o), (k == 1 || k == 2) ? 40'h2 : 40'h0);
      chk_reg(REG_CTRL, {30'h0, wq[k][2], wq[k][0]});
    end
    set_acc(2'd0, 40'h0);
    run({8'h00, 24'h000000});
    chk_reg(REG_STATUS, 32'h0000_0010);
    chk_acc(2'd0, 40'h0);
  endtask : t_ovf

  // ==========================================================================
  // main sequence
  initial
  begin
    {n_fail, comparisons, cycles} = '0;
    rst_i = 1'b1;
    {wb_cyc_i, wb_stb_i, wb_we_i, instr_valid_i} = 4'h0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'hf;
    wb_dat_i = 32'h0;
    instr_i = '0;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_regs();
    t_shared();
    t_shifted();
    t_long();
    t_frac();
    t_round();
    t_ovf();
    end_sim();
  end
endmodule : testbench
